// File: rtl/cpdc_defines.svh
`ifndef CPDC_DEFINES_SVH
`define CPDC_DEFINES_SVH

// sample clock rate in MHz
`define CPDC_CLK_MHZ 100
// converter core wake time, microseconds
`define CPDC_CORE_WAKE_US 2
// pll settle time, microseconds
`define CPDC_PLL_WAKE_US 20
// least times, in whole clock cycles, rounded up
`define CPDC_CORE_WAKE_CYC ((`CPDC_CORE_WAKE_US * `CPDC_CLK_MHZ * 1000 + 999) / 1000)
`define CPDC_PLL_WAKE_CYC ((`CPDC_PLL_WAKE_US * `CPDC_CLK_MHZ * 1000 + 999) / 1000)
// conversion code width
`define CPDC_CODE_W 8
// reset value of the held output code
`define CPDC_CODE_RST 8'h00

`endif

// File: rtl/cpdc_pkg.sv
package cpdc_pkg;

    // power modes of the device
    typedef enum logic [1:0] {
        CPDC_RUN        = 2'b00,
        CPDC_CONV_SLEEP = 2'b01,
        CPDC_FULL_SLEEP = 2'b10
    } cpdc_mode_t;

    // sleep requests from the controller
    typedef struct packed {
        logic full_sleep_request;
        logic converter_sleep_request;
    } cpdc_req_t;

    // power gates toward the analog and buffer sections
    typedef struct packed {
        logic core_power_en;
        logic pll_power_en;
        logic buffer_power_en;
    } cpdc_gate_t;

endpackage : cpdc_pkg

// File: rtl/cpdc_settle_timer.sv
`timescale 1ns/1ps
`include "cpdc_defines.svh"

module cpdc_settle_timer #(
    parameter int COUNT = `CPDC_CORE_WAKE_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hold,
    output logic done
);
    localparam int W = $clog2(COUNT + 1);

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic next_done;

    ////////////////////////////////////////////////////////////////////////
    // refuse a settle time that cannot be counted
    if (COUNT < 1) begin : g_bad_count
        $error("cpdc_settle_timer: COUNT must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////
    // cleared while held, counts up to COUNT once released
    always_comb begin
        next_count = count;
        next_done = done;
        if (hold) begin
            next_count = '0;
            next_done = 1'b0;
        end else if (!done) begin
            next_count = count + W'(1);
            next_done = (count + W'(1)) == W'(COUNT);
        end
    end

    // state registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            done <= next_done;
        end
    end

endmodule : cpdc_settle_timer

// File: rtl/cpdc_top.sv
// Operation
// - full sleep powers down, conversion halts
// - core ready 2 us after full sleep
// - pll ready 20 us after full sleep
// - output code held while asleep
// - entering full sleep discards buffer
// - converter sleep: core off, buffer kept
// - core ready 2 us after converter sleep
// - pll stays on in converter sleep
// - full sleep wins over converter sleep
`timescale 1ns/1ps
`include "cpdc_defines.svh"

module cpdc_top #(
    parameter int CODE_W = `CPDC_CODE_W,
    parameter int CORE_WAKE_CYC = `CPDC_CORE_WAKE_CYC,
    parameter int PLL_WAKE_CYC = `CPDC_PLL_WAKE_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire cpdc_pkg::cpdc_req_t sleep_req,
    input wire logic pll_in_use,
    input wire logic conv_valid,
    input wire logic [CODE_W-1:0] conv_code,
    output cpdc_pkg::cpdc_gate_t gates,
    output logic buffer_discard,
    output logic [CODE_W-1:0] data_out,
    output logic converter_ready,
    output logic pll_settled,
    output logic sample_ready
);
    localparam int CORE_CYC_I = CORE_WAKE_CYC;
    localparam int PLL_CYC_I = PLL_WAKE_CYC;

    cpdc_pkg::cpdc_mode_t mode;
    cpdc_pkg::cpdc_mode_t next_mode;
    logic next_buffer_discard;
    logic [CODE_W-1:0] next_data_out;
    logic pll_done;
    logic core_done;

    ////////////////////////////////////////////////////////////////////////
    // refuse widths the output path cannot serve
    if (CODE_W < 1) begin : g_bad_width
        $error("cpdc_top: CODE_W must be at least 1");
    end

    // the wake checks below need eight held-off cycles after wake
    if (CORE_WAKE_CYC < 8 || PLL_WAKE_CYC < 1) begin : g_bad_wake
        $error("cpdc_top: wake counts too small for the wake checks");
    end

    ////////////////////////////////////////////////////////////////////////
    // power mode from the two request levels
    always_comb begin
        next_mode = cpdc_pkg::CPDC_RUN;
        if (sleep_req.full_sleep_request) begin
            next_mode = cpdc_pkg::CPDC_FULL_SLEEP;
        end else if (sleep_req.converter_sleep_request) begin
            next_mode = cpdc_pkg::CPDC_CONV_SLEEP;
        end
        // one-cycle discard on entry to full sleep
        next_buffer_discard = sleep_req.full_sleep_request &&
            (mode != cpdc_pkg::CPDC_FULL_SLEEP);
    end

    // mode registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode <= cpdc_pkg::CPDC_RUN;
            buffer_discard <= 1'b0;
        end else begin
            mode <= next_mode;
            buffer_discard <= next_buffer_discard;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gates follow the registered mode
    always_comb begin
        gates.core_power_en = (mode == cpdc_pkg::CPDC_RUN);
        gates.pll_power_en = (mode != cpdc_pkg::CPDC_FULL_SLEEP);
        gates.buffer_power_en = (mode != cpdc_pkg::CPDC_FULL_SLEEP);
    end

    ////////////////////////////////////////////////////////////////////////
    // core settle timer, held while the core is off
    cpdc_settle_timer #(
        .COUNT(CORE_WAKE_CYC)
    ) u_core_timer (
        .clk(clk),
        .reset_n(reset_n),
        .hold(mode != cpdc_pkg::CPDC_RUN),
        .done(core_done)
    );

    // pll timer, re-armed only by full sleep; a stopped clock is not seen
    cpdc_settle_timer #(
        .COUNT(PLL_WAKE_CYC)
    ) u_pll_timer (
        .clk(clk),
        .reset_n(reset_n),
        .hold(mode == cpdc_pkg::CPDC_FULL_SLEEP),
        .done(pll_done)
    );

    // readiness as seen by the capture side; the core flag drops
    // on the very edge that leaves run, not one cycle later
    always_comb begin
        converter_ready = core_done && (mode == cpdc_pkg::CPDC_RUN);
        pll_settled = pll_done || !pll_in_use;
        sample_ready = converter_ready && pll_settled;
    end

    ////////////////////////////////////////////////////////////////////////
    // output code, updated only while converting and settled
    always_comb begin
        next_data_out = data_out;
        if (mode == cpdc_pkg::CPDC_RUN && sample_ready && conv_valid) begin
            next_data_out = conv_code;
        end
    end

    // held code register; holds through sleep and a stopped clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= CODE_W'(`CPDC_CODE_RST);
        end else begin
            data_out <= next_data_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helper counters of settling cycles for the checks below
    int core_wait;
    int pll_wait;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            core_wait <= 0;
            pll_wait <= 0;
        end else begin
            core_wait <= (mode != cpdc_pkg::CPDC_RUN) ? 0 :
                (converter_ready ? core_wait : core_wait + 1);
            pll_wait <= (mode == cpdc_pkg::CPDC_FULL_SLEEP) ? 0 :
                (pll_done ? pll_wait : pll_wait + 1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake sequences
    sequence s_full_wake;
        (mode == cpdc_pkg::CPDC_FULL_SLEEP) ##1 (mode == cpdc_pkg::CPDC_RUN);
    endsequence

    sequence s_conv_wake;
        (mode == cpdc_pkg::CPDC_CONV_SLEEP) ##1 (mode == cpdc_pkg::CPDC_RUN);
    endsequence

    AST_FULL_SLEEP_OFF: assert property (
        @(posedge clk) disable iff (!reset_n)
        sleep_req.full_sleep_request |=>
            !gates.core_power_en && !gates.pll_power_en && !converter_ready)
        else $error("full sleep left core or pll powered");

    AST_CORE_WAKE_FULL: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_full_wake |-> !converter_ready [*8])
        else $error("core ready too soon after full sleep");

    AST_CORE_WAKE_EXACT: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(converter_ready) |-> (core_wait == CORE_CYC_I))
        else $error("core settle count wrong");

    AST_PLL_WAKE_EXACT: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(pll_done) |-> (pll_wait == PLL_CYC_I))
        else $error("pll settle count wrong");

    AST_HOLD_CODE: assert property (
        @(posedge clk) disable iff (!reset_n)
        (mode != cpdc_pkg::CPDC_RUN) |=> (data_out == $past(data_out)))
        else $error("output code changed while asleep");

    AST_DISCARD_PULSE: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(sleep_req.full_sleep_request) |=> buffer_discard ##1 !buffer_discard)
        else $error("buffer discard not a single pulse on full sleep");

    AST_CONV_SLEEP_GATES: assert property (
        @(posedge clk) disable iff (!reset_n)
        (sleep_req.converter_sleep_request && !sleep_req.full_sleep_request) |=>
            !gates.core_power_en && gates.buffer_power_en)
        else $error("converter sleep gated wrong section");

    AST_CORE_WAKE_CONV: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_conv_wake |-> !converter_ready [*8])
        else $error("core ready too soon after converter sleep");

    AST_PLL_KEPT: assert property (
        @(posedge clk) disable iff (!reset_n)
        (mode == cpdc_pkg::CPDC_CONV_SLEEP) |-> gates.pll_power_en && !$fell(pll_done))
        else $error("pll disturbed by converter sleep");

    AST_PRECEDENCE: assert property (
        @(posedge clk) disable iff (!reset_n)
        (sleep_req.full_sleep_request && sleep_req.converter_sleep_request) |=>
            (mode == cpdc_pkg::CPDC_FULL_SLEEP) && !gates.buffer_power_en)
        else $error("full sleep did not dominate");

    AST_READY_JOIN: assert property (
        @(posedge clk) disable iff (!reset_n)
        sample_ready |-> (mode == cpdc_pkg::CPDC_RUN) && (core_wait >= CORE_CYC_I) &&
            (!pll_in_use || (pll_wait >= PLL_CYC_I)))
        else $error("sample ready without settling");

    AST_DATA_TAKEN: assert property (
        @(posedge clk) disable iff (!reset_n)
        (mode == cpdc_pkg::CPDC_RUN && sample_ready && conv_valid) |=>
            (data_out == $past(conv_code)))
        else $error("settled conversion code not taken");

endmodule : cpdc_top

// File: dv/cpdc_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// controller side: drives the two sleep levels off the falling edge
module cpdc_host_model (
    input wire logic clk,
    input wire logic want_full,
    input wire logic want_conv,
    input wire logic sample_ready,
    output cpdc_pkg::cpdc_req_t sleep_req,
    output logic may_sample
);
    cpdc_pkg::cpdc_req_t pending = '0;
    // wishes taken at the rising edge, so a wish set at the falling edge never races
    always @(posedge clk) begin
        pending.full_sleep_request <= want_full;
        pending.converter_sleep_request <= want_conv;
    end
    // levels change only off the sampling edge
    initial sleep_req = '0;
    always @(negedge clk) begin
        sleep_req <= pending;
    end
    // no capture trusted before the device reports settled
    assign may_sample = sample_ready;
endmodule : cpdc_host_model

// File: dv/converter_power_down_control_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
////////////////////////////////////////////////////////////////////////////////
module converter_power_down_control_test;
    localparam int CORE = 10;
    localparam int PLL = 20;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic want_full = 1'b0;
    logic want_conv = 1'b0;
    logic pll_in_use = 1'b1;
    logic conv_valid = 1'b0;
    logic [7:0] conv_code = 8'h00;
    cpdc_pkg::cpdc_req_t sleep_req;
    cpdc_pkg::cpdc_gate_t gates;
    logic buffer_discard;
    logic converter_ready;
    logic pll_settled;
    logic sample_ready;
    logic may_sample;
    logic [7:0] data_out;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int nc;
    int np;
    always #5 clk = ~clk;
    cpdc_top #(.CODE_W(8), .CORE_WAKE_CYC(CORE), .PLL_WAKE_CYC(PLL)) u_dut (
        .clk(clk), .reset_n(reset_n), .sleep_req(sleep_req), .pll_in_use(pll_in_use),
        .conv_valid(conv_valid), .conv_code(conv_code), .gates(gates),
        .buffer_discard(buffer_discard), .data_out(data_out),
        .converter_ready(converter_ready), .pll_settled(pll_settled),
        .sample_ready(sample_ready));
    cpdc_host_model u_host (
        .clk(clk), .want_full(want_full), .want_conv(want_conv),
        .sample_ready(sample_ready), .sleep_req(sleep_req), .may_sample(may_sample));
    ////////////////////////////////////////////////////////////////////////////
    // closing report
    task stop_test;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    // edges until each ready flag rises, from now
    task count_ready;
        nc = 0;
        np = pll_settled ? 0 : -1;
        for (int i = 1; i <= 3 * PLL; i++) begin
            @(posedge clk);
            #1;
            if (converter_ready === 1'b1 && nc == 0) nc = i;
            if (pll_settled === 1'b1 && np < 0) np = i;
        end
        @(negedge clk);
    endtask : count_ready
    // one conversion offered for a cycle
    task offer(input logic [7:0] code);
        conv_valid = 1'b1;
        conv_code = code;
        @(negedge clk);
        conv_valid = 1'b0;
    endtask : offer
    ////////////////////////////////////////////////////////////////////////////
    // reset values and first settling
    task scn_reset;
        `CHK(gates, 3'b111)
        `CHK(data_out, 8'h00)
        `CHK(sample_ready, 1'b0)
        reset_n = 1'b1;
        offer(8'h77);
        `CHK(data_out, 8'h00)
        count_ready();
        `CHK(nc, CORE - 1)
        `CHK(np, PLL - 1)
    endtask : scn_reset
    // full sleep: gates, discard, held code, wake times
    task scn_full(input logic conv_too);
        offer(8'hA5);
        `CHK(data_out, 8'hA5)
        want_full = 1'b1;
        want_conv = conv_too;
        @(posedge clk);
        @(posedge clk);
        #1;
        `CHK(gates, 3'b000)
        `CHK(buffer_discard, 1'b1)
        `CHK(converter_ready, 1'b0)
        @(negedge clk);
        offer(8'h3C);
        `CHK(buffer_discard, 1'b0)
        `CHK(gates, 3'b000)
        `CHK(data_out, 8'hA5)
        want_full = 1'b0;
        want_conv = 1'b0;
        @(posedge clk);
        @(posedge clk);
        #1;
        `CHK(gates, 3'b111)
        `CHK(may_sample, 1'b0)
        count_ready();
        `CHK(nc, CORE)
        `CHK(np, pll_in_use ? PLL : 0)
        `CHK(may_sample, 1'b1)
    endtask : scn_full
    // converter sleep: buffer and pll stay up
    task scn_conv;
        want_conv = 1'b1;
        @(posedge clk);
        @(posedge clk);
        #1;
        `CHK(gates, 3'b011)
        `CHK(buffer_discard, 1'b0)
        `CHK(pll_settled, 1'b1)
        @(negedge clk);
        offer(8'h5A);
        `CHK(data_out, 8'hA5)
        want_conv = 1'b0;
        @(posedge clk);
        @(posedge clk);
        #1;
        `CHK(gates, 3'b111)
        count_ready();
        `CHK(nc, CORE)
        `CHK(np, 0)
        offer(8'hC3);
        `CHK(data_out, 8'hC3)
    endtask : scn_conv
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge clk);
        scn_reset();
        scn_full(1'b0);
        scn_conv();
        scn_full(1'b1);
        pll_in_use = 1'b0;
        scn_full(1'b0);
        stop_test();
    end
endmodule : converter_power_down_control_test
